// ==== dv/cpms_pwr_model.sv ====
/*
 Power controller model: cuts power after ready, then resets the CPU.
 Assumes the sequencer clock; kick is a bench-commanded reset.
*/
module cpms_pwr_model
    import cpms_pkg::*;
#(
    parameter int N = CPMS_NUM_CPUS
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // From sequencer and bench
    input  wire logic [N-1:0] ready,
    input  wire logic [N-1:0] kick,
    // To sequencer
    output logic      [N-1:0] pwr_off,
    output logic      [N-1:0] cpu_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    // Never cut power early; state counted as saved once ready
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pwr_off   <= '0;
            cpu_reset <= '0;
        end
        else
        begin
            pwr_off   <= (pwr_off | ready) & ~cpu_reset;
            cpu_reset <= kick | pwr_off;
        end
    end
endmodule : cpms_pwr_model

// ==== dv/cpms_top_monitor.sv ====
/*
 Port checker of the sequencer top, bound into it.
 Assumes the default build, power-off wrappers omitted.
*/
module cpms_top_monitor
    import cpms_pkg::*;
#(
    parameter int N = CPMS_NUM_CPUS,
    parameter int W = CPMS_IRQ_PER_CPU
)
(
    // Clock, reset and watched ports
    input wire logic           CLOCK,
    input wire logic           RST,
    input wire logic [N*W-1:0] IRQ_N,
    input wire logic [N-1:0]   DEBUG_REQ,
    input wire logic [N-1:0]   STANDBY_REQ,
    input wire logic [N-1:0]   CPU_RESET,
    input wire logic [N*3-1:0] MODE,
    input wire logic [N-1:0]   CLK_EN,
    input wire logic [N-1:0]   IRQ_BLOCK,
    input wire logic [N-1:0]   PWR_READY,
    input wire logic [N-1:0]   CLAMP_REQ,
    input wire logic [N-1:0]   CACHE_RETAIN
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    for (genvar i = 0; i < N; i++)
    begin : g_cpu
        // Mode of one CPU and its wake causes
        wire logic [2:0] m = MODE[3*i+:3];
        wire logic run = (m == CPMS_RUN);
        wire logic sb = (m == CPMS_STANDBY);
        wire logic irq = !(&IRQ_N[W*i+:W]);
        wire logic wake = irq || DEBUG_REQ[i] || CPU_RESET[i];
        property p_run_clk; run |-> CLK_EN[i]; endproperty
        a_run_clk: assert property (p_run_clk) else $error("clock off in run");
        property p_sb_in; run && STANDBY_REQ[i] |=> sb && !CLK_EN[i]; endproperty
        a_sb_in: assert property (p_sb_in) else $error("no standby");
        property p_sb_clk; sb |-> !CLK_EN[i]; endproperty
        a_sb_clk: assert property (p_sb_clk) else $error("clock in standby");
        property p_irq_wake; sb && irq |-> ##[1:4] run; endproperty
        a_irq_wake: assert property (p_irq_wake) else $error("no irq wake");
        property p_dbg_wake; sb && DEBUG_REQ[i] |-> ##[1:4] run; endproperty
        a_dbg_wake: assert property (p_dbg_wake) else $error("no debug wake");
        property p_rst_wake; sb && CPU_RESET[i] |-> ##[1:4] run; endproperty
        a_rst_wake: assert property (p_rst_wake) else $error("no reset wake");
        property p_sb_hold; !wake [*4] ##0 sb |=> sb; endproperty
        a_sb_hold: assert property (p_sb_hold) else $error("woke uncaused");
        property p_run_stay; run && !STANDBY_REQ[i] |=> run; endproperty
        a_run_stay: assert property (p_run_stay) else $error("left run");
        property p_blk_off; run || sb |-> !IRQ_BLOCK[i]; endproperty
        a_blk_off: assert property (p_blk_off) else $error("interrupts blocked");
        property p_opt_off; !PWR_READY[i] && !CLAMP_REQ[i] && CACHE_RETAIN[i]; endproperty
        a_opt_off: assert property (p_opt_off) else $error("power-off active");
    end
    // Main scenarios
    c_wake: cover property (g_cpu[0].sb ##1 g_cpu[0].run);
    c_all: cover property (MODE == {N{3'h1}});
    c_dbg: cover property (g_cpu[2].sb && DEBUG_REQ[2]);
endmodule : cpms_top_monitor
bind cpms_top cpms_top_monitor i_cpms_top_monitor (.CLOCK, .RST, .IRQ_N, .DEBUG_REQ,
    .STANDBY_REQ, .CPU_RESET, .MODE, .CLK_EN, .IRQ_BLOCK, .PWR_READY, .CLAMP_REQ,
    .CACHE_RETAIN);

// ==== dv/tb_cpms_top.sv ====
/*
 Bench of the sequencer: wake causes, ignored requests, mid reset.
 Assumes the default build of the package.
*/
module tb_cpms_top
    import cpms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = CPMS_NUM_CPUS;
    localparam int W = CPMS_IRQ_PER_CPU;
    // Row: cpu, cause (0 irq, 1 debug, 2 reset), line, mode, clock
    typedef struct {int cpu; int cause; int line; logic [2:0] md; logic ck;} cpms_row_type;
    cpms_row_type rows [8] = '{'{0, 0, 0, 3'h0, 1'h1}, '{1, 0, 31, 3'h0, 1'h1},
        '{2, 1, 0, 3'h0, 1'h1}, '{3, 2, 0, 3'h0, 1'h1}, '{0, 1, 0, 3'h0, 1'h1},
        '{1, 2, 0, 3'h0, 1'h1}, '{2, 0, 17, 3'h0, 1'h1}, '{3, 0, 5, 3'h0, 1'h1}};
    logic           clock, rst;
    logic [N*W-1:0] irq_n;
    logic [N-1:0]   debug_req, standby_req, dormant_req, shutdown_req, save_done;
    logic [N-1:0]   barrier_done, kick, pwr_off, cpu_reset, clk_en, irq_block;
    logic [N-1:0]   pwr_ready, clamp_req, cache_retain;
    logic [N*3-1:0] mode;
    int             errors, tests_run, cycles;
    cpms_top i_cpms_top (.CLOCK(clock), .RST(rst), .IRQ_N(irq_n), .DEBUG_REQ(debug_req),
        .STANDBY_REQ(standby_req), .DORMANT_REQ(dormant_req), .SHUTDOWN_REQ(shutdown_req),
        .SAVE_DONE(save_done), .BARRIER_DONE(barrier_done), .PWR_OFF(pwr_off),
        .CPU_RESET(cpu_reset), .MODE(mode), .CLK_EN(clk_en), .IRQ_BLOCK(irq_block),
        .PWR_READY(pwr_ready), .CLAMP_REQ(clamp_req), .CACHE_RETAIN(cache_retain));
    cpms_pwr_model i_cpms_pwr_model (.clk(clock), .rst(rst), .ready(pwr_ready),
        .kick(kick), .pwr_off(pwr_off), .cpu_reset(cpu_reset));
    // 100 MHz clock
    initial
    begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    // Hang guard, far above the run length
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            report_and_stop();
        end
    end
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic go_standby(int c);
        @(negedge clock) standby_req[c] = 1'h1;
        @(negedge clock) standby_req[c] = 1'h0;
        check("mode", mode[3*c+:3], 3'h1);
        check("clk_en", clk_en[c], 1'h0);
    endtask : go_standby
    // Bounded wait, sync latency plus margin
    task automatic wait_run(int c);
        int k = 0;
        while (mode[3*c+:3] !== 3'h0 && k < 8)
        begin
            @(negedge clock);
            k++;
        end
    endtask : wait_run
    initial
    begin
        rst = 1'h1;
        irq_n = '1;
        {debug_req, standby_req, dormant_req, shutdown_req, save_done} = '0;
        {barrier_done, kick} = '0;
        repeat (2) @(negedge clock);
        check("mode", mode, '0);
        check("outs", {cache_retain, irq_block, pwr_ready, clamp_req}, 16'hF000);
        rst = 1'h0;
        repeat (4) @(negedge clock);
        // Each wake cause, line held until the CPU runs again
        foreach (rows[r])
        begin
            go_standby(rows[r].cpu);
            repeat (4) @(negedge clock);
            check("mode", mode[3*rows[r].cpu+:3], 3'h1);
            case (rows[r].cause)
                0: irq_n[W*rows[r].cpu+rows[r].line] = 1'h0;
                1: debug_req[rows[r].cpu] = 1'h1;
                default: kick[rows[r].cpu] = 1'h1;
            endcase
            wait_run(rows[r].cpu);
            check("mode", mode[3*rows[r].cpu+:3], rows[r].md);
            check("clk_en", clk_en[rows[r].cpu], rows[r].ck);
            irq_n = '1;
            {debug_req, kick} = '0;
            repeat (4) @(negedge clock);
        end
        // Wakes and power-off requests while running are ignored
        irq_n = '0;
        {debug_req, kick, dormant_req, shutdown_req, save_done, barrier_done} = '1;
        repeat (6) @(negedge clock);
        check("mode", mode, '0);
        check("outs", {cache_retain, irq_block, pwr_ready, clamp_req}, 16'hF000);
        irq_n = '1;
        {debug_req, kick, dormant_req, shutdown_req, save_done, barrier_done} = '0;
        repeat (4) @(negedge clock);
        // All asleep, one woken, then reset in mid-standby
        @(negedge clock) standby_req = '1;
        @(negedge clock) standby_req = '0;
        check("mode", mode, 12'h249);
        debug_req[2] = 1'h1;
        wait_run(2);
        debug_req = '0;
        check("mode", mode, 12'h209);
        @(negedge clock) rst = 1'h1;
        #1;
        check("mode", mode, '0);
        // Request on the first edge after release: no false wake may follow
        @(negedge clock) rst = 1'h0;
        standby_req[0] = 1'h1;
        @(negedge clock) standby_req[0] = 1'h0;
        check("clk_en", clk_en, 4'hE);
        repeat (4) @(negedge clock);
        check("mode", mode, 12'h001);
        report_and_stop();
    end
endmodule : tb_cpms_top

// ==== hdl/cpms_pkg.sv ====
/*
 Package for the per-CPU power-mode sequencer: build options, widths,
 mode encoding and the per-CPU state record of the sequencer top.
 Assumes a single CPU clock domain and an asynchronous active-high reset.
*/
package cpms_pkg;

    // Build options
    localparam int  CPMS_NUM_CPUS      = 4;
    localparam int  CPMS_MAX_CPUS      = 4;
    localparam int  CPMS_IRQ_WIDTH     = 32;
    localparam int  CPMS_IRQ_STEP      = 32;
    localparam int  CPMS_IRQ_MAX       = 224;
    localparam bit  CPMS_PWR_WRAPPERS  = 1'b0;
    localparam int  CPMS_IRQ_PER_CPU   = (CPMS_IRQ_WIDTH > 0) ? CPMS_IRQ_WIDTH : 1;

    // Reset values
    localparam logic CPMS_RST_CLK_EN   = 1'b1;
    localparam logic CPMS_RST_PWR_REQ  = 1'b0;

    // Power modes of one CPU
    typedef enum logic [2:0]
    {
        CPMS_RUN,
        CPMS_STANDBY,
        CPMS_SAVE,
        CPMS_BARRIER,
        CPMS_READY,
        CPMS_DORMANT,
        CPMS_SHUTDOWN
    } cpms_mode_type;

    // State of one CPU's sequencer
    typedef struct packed
    {
        cpms_mode_type mode;
        logic          clk_en;
        logic          irq_block;
        logic          pwr_ready;
        logic          clamp_req;
        logic          retain;
    } cpms_cpu_type;

endpackage : cpms_pkg

// ==== hdl/cpms_sync.sv ====
/*
 Two-flop level synchroniser for a bus of asynchronous inputs.
 Assumes the inputs are levels held longer than two clock periods.
*/
module cpms_sync
    import cpms_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    typedef struct packed
    {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } cpms_sync_type;

    cpms_sync_type state;
    cpms_sync_type next_state;

    // First stage is read only by the second stage
    always_comb
    begin
        next_state        = state;
        next_state.meta   = d;
        next_state.stable = state.meta;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign q = state.stable;

endmodule : cpms_sync

// ==== hdl/cpms_top.sv ====
/*
 Per-CPU power-mode sequencer: run, standby, dormant and shutdown with
 the save handshake toward the external power controller.
 Outputs are registered copies of each CPU's state record.
 Assumes interrupts, debug requests and controller inputs arrive
 asynchronously; the CPU core drives its own requests on this clock.
*/
module cpms_top
    import cpms_pkg::*;
(
    // Clock and reset
    input  wire logic                                 CLOCK,
    input  wire logic                                 RST,
    // Wake sources, asynchronous
    input  wire logic [CPMS_NUM_CPUS*CPMS_IRQ_PER_CPU-1:0] IRQ_N,
    input  wire logic [CPMS_NUM_CPUS-1:0]              DEBUG_REQ,
    // Requests from each CPU core, same clock
    input  wire logic [CPMS_NUM_CPUS-1:0]              STANDBY_REQ,
    input  wire logic [CPMS_NUM_CPUS-1:0]              DORMANT_REQ,
    input  wire logic [CPMS_NUM_CPUS-1:0]              SHUTDOWN_REQ,
    input  wire logic [CPMS_NUM_CPUS-1:0]              SAVE_DONE,
    input  wire logic [CPMS_NUM_CPUS-1:0]              BARRIER_DONE,
    // From the power controller, asynchronous
    input  wire logic [CPMS_NUM_CPUS-1:0]              PWR_OFF,
    input  wire logic [CPMS_NUM_CPUS-1:0]              CPU_RESET,
    // Status and controls
    output logic      [CPMS_NUM_CPUS*3-1:0]            MODE,
    output logic      [CPMS_NUM_CPUS-1:0]              CLK_EN,
    output logic      [CPMS_NUM_CPUS-1:0]              IRQ_BLOCK,
    output logic      [CPMS_NUM_CPUS-1:0]              PWR_READY,
    output logic      [CPMS_NUM_CPUS-1:0]              CLAMP_REQ,
    output logic      [CPMS_NUM_CPUS-1:0]              CACHE_RETAIN
);

    localparam int N = CPMS_NUM_CPUS;
    localparam int W = CPMS_IRQ_PER_CPU;

    // One record per CPU, registered as a whole
    typedef struct packed
    {
        cpms_cpu_type [N-1:0] cpu;
    } cpms_top_type;

    cpms_top_type state;
    cpms_top_type next_state;

    // Synchronised wake and controller inputs, all active high
    logic [N*W-1:0] irq_s;
    logic [N-1:0]   dbg_s;
    logic [N-1:0]   off_s;
    logic [N-1:0]   crst_s;

    // Asynchronous inputs pass two flops first
    // Interrupt lines enter inverted: a cleared synchroniser then reads
    // idle, where a cleared active-low copy would fake a wake after reset
    cpms_sync #(.WIDTH(N*W)) u_sync_irq
    (
        .clk (CLOCK),
        .rst (RST),
        .d   (~IRQ_N),
        .q   (irq_s)
    );

    cpms_sync #(.WIDTH(3*N)) u_sync_misc
    (
        .clk (CLOCK),
        .rst (RST),
        .d   ({DEBUG_REQ, PWR_OFF, CPU_RESET}),
        .q   ({dbg_s, off_s, crst_s})
    );

    // Any asserted line wakes; no mask is consulted here
    function automatic logic cpms_irq_any(input logic [W-1:0] lines);
        // A build with no interrupt bus never wakes this way
        cpms_irq_any = (CPMS_IRQ_WIDTH > 0) && (|lines);
    endfunction : cpms_irq_any

    // Fill the derived outputs of one CPU from its mode
    function automatic cpms_cpu_type cpms_outputs(input cpms_cpu_type c);
        cpms_outputs           = c;
        cpms_outputs.clk_en    = (c.mode == CPMS_RUN) || (c.mode == CPMS_SAVE)
                                 || (c.mode == CPMS_BARRIER);
        cpms_outputs.irq_block = (c.mode == CPMS_SAVE) || (c.mode == CPMS_BARRIER)
                                 || (c.mode == CPMS_READY);
        cpms_outputs.pwr_ready = (c.mode == CPMS_READY);
        cpms_outputs.clamp_req = (c.mode == CPMS_DORMANT);
        cpms_outputs.retain    = (c.mode != CPMS_SHUTDOWN);
    endfunction : cpms_outputs

    // Per-CPU mode sequencing
    always_comb
    begin
        next_state = state;
        for (int i = 0; i < N; i++)
        begin
            case (state.cpu[i].mode)
                CPMS_RUN:
                begin
                    // Wake events have no effect here
                    // Standby takes priority over the power-off requests
                    if (STANDBY_REQ[i])
                    begin
                        next_state.cpu[i].mode = CPMS_STANDBY;
                    end
                    else if (CPMS_PWR_WRAPPERS && SHUTDOWN_REQ[i])
                    begin
                        next_state.cpu[i].mode = CPMS_SAVE;
                    end
                    else if (CPMS_PWR_WRAPPERS && DORMANT_REQ[i])
                    begin
                        next_state.cpu[i].mode = CPMS_DORMANT;
                    end
                end
                CPMS_STANDBY:
                begin
                    // Exactly three wake causes
                    // Causes arrive through the synchronisers, two edges late
                    if (cpms_irq_any(irq_s[i*W +: W]) || dbg_s[i] || crst_s[i])
                    begin
                        next_state.cpu[i].mode = CPMS_RUN;
                    end
                end
                CPMS_SAVE:
                begin
                    // Software copies state out; interrupts held off
                    if (SAVE_DONE[i])
                    begin
                        next_state.cpu[i].mode = CPMS_BARRIER;
                    end
                end
                CPMS_BARRIER:
                begin
                    // Clocks stay on so outstanding accesses can finish
                    // Ready only once memory accesses drain
                    if (BARRIER_DONE[i])
                    begin
                        next_state.cpu[i].mode = CPMS_READY;
                    end
                end
                CPMS_READY:
                begin
                    // Power is removed by the controller, never by this block
                    if (off_s[i])
                    begin
                        next_state.cpu[i].mode = CPMS_SHUTDOWN;
                    end
                end
                CPMS_DORMANT, CPMS_SHUTDOWN:
                begin
                    // Return only by reset after power comes back
                    if (crst_s[i])
                    begin
                        next_state.cpu[i].mode = CPMS_RUN;
                    end
                end
                default:
                begin
                    // Unused codes fall back to run
                    next_state.cpu[i].mode = CPMS_RUN;
                end
            endcase
            // Outputs are registered with the mode, so they never glitch
            next_state.cpu[i] = cpms_outputs(next_state.cpu[i]);
        end
    end

    // Reset lands every CPU in run with clocks on
    // Reset branch holds constants only
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            for (int i = 0; i < N; i++)
            begin
                state.cpu[i].mode      <= CPMS_RUN;
                state.cpu[i].clk_en    <= CPMS_RST_CLK_EN;
                state.cpu[i].irq_block <= 1'b0;
                state.cpu[i].pwr_ready <= CPMS_RST_PWR_REQ;
                state.cpu[i].clamp_req <= 1'b0;
                state.cpu[i].retain    <= 1'b1;
            end
        end
        else
        begin
            state <= next_state;
        end
    end

    // Outputs straight from the state flops
    // Plain wiring: no logic between the flops and the pins
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            MODE[i*3 +: 3]  = state.cpu[i].mode;
            CLK_EN[i]       = state.cpu[i].clk_en;
            IRQ_BLOCK[i]    = state.cpu[i].irq_block;
            PWR_READY[i]    = state.cpu[i].pwr_ready;
            CLAMP_REQ[i]    = state.cpu[i].clamp_req;
            CACHE_RETAIN[i] = state.cpu[i].retain;
        end
    end

endmodule : cpms_top
